// File: include/spfs_defs.svh
// Named constants for the shared pin function select block.
// Assumes inclusion by bare name from the package and the core files.
`ifndef SPFS_DEFS_SVH
`define SPFS_DEFS_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define SPFS_OFS_TIMER_CTRL   5'h00
`define SPFS_OFS_DMA_MODE     5'h04
`define SPFS_OFS_SER_CTRL_CH1 5'h08
`define SPFS_OFS_SER_STAT_CH1 5'h0C
`define SPFS_OFS_PIN_STATUS   5'h10

// ==========================================================================
// Field positions
// ==========================================================================
`define SPFS_BIT_TOC_LO       0
`define SPFS_BIT_TOC_HI       1
`define SPFS_BIT_DMA_DST_HI   0
`define SPFS_BIT_DMA_SRC_HI   1
`define SPFS_BIT_SCLK1_DIS    0
`define SPFS_BIT_CLEAR_TO_SEND_CH1_EN      0
`define SPFS_LANE_LO          0

// ==========================================================================
// Widths and reset values
// ==========================================================================
`define SPFS_ADDR_W           5
`define SPFS_DATA_W           32
`define SPFS_CTRL_W           2
`define SPFS_CTRL_RST         2'h0
`define SPFS_DATA_ZERO        32'h0000_0000
`define SPFS_LINE_IDLE        1'b1
`define SPFS_LINE_LOW         1'b0

`endif

// File: include/spfs_pkg.sv
// Types shared by the shared pin function select core files.
// Assumes spfs_defs.svh is on the include path.
`include "spfs_defs.svh"

package spfs_pkg;

  // ========================================================================
  // Carriers
  // ========================================================================
  // One output function as offered to a pin: level and whether it drives.
  typedef struct packed {
    logic level;
    logic drive;
  } spfs_fn_t;

  // Bus handshake states.
  typedef enum logic [0:0] {
    SPFS_BUS_WAIT = 1'b0,
    SPFS_BUS_ACK  = 1'b1
  } spfs_bus_t;

endpackage : spfs_pkg

// File: core/spfs_pin_cell.sv
// One shared pin: selects between two functions and registers the pad.
// Assumes the select is already resolved; the pad wire is formed outside.
`timescale 1ns/100ps
`default_nettype none
`include "spfs_defs.svh"

module spfs_pin_cell #(
  parameter logic RST_OE_N = 1'b1,
  parameter logic IDLE_A   = 1'b1,
  parameter logic IDLE_B   = 1'b1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Selection and function sources
  input  wire logic             selB,
  input  wire spfs_pkg::spfs_fn_t fnA,
  input  wire spfs_pkg::spfs_fn_t fnB,
  // Function inputs seen by the core
  output logic                  fnAIn,
  output logic                  fnBIn,
  // Pad
  input  wire logic             padIn,
  output logic                  padOut,
  output logic                  padOe_n
);

  // ========================================================================
  // Selection
  // ========================================================================
  wire logic selLevel = selB ? fnB.level : fnA.level;
  wire logic selDrive = selB ? fnB.drive : fnA.drive;
  // The unselected function sees its idle level so it never reacts to the pad.
  wire logic aInD     = selB ? IDLE_A : padIn;
  wire logic bInD     = selB ? padIn : IDLE_B;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      padOut  <= `SPFS_LINE_LOW;
      padOe_n <= RST_OE_N;
      fnAIn   <= IDLE_A;
      fnBIn   <= IDLE_B;
    end
    else
    begin
      padOut  <= selLevel;
      padOe_n <= ~selDrive;
      fnAIn   <= aInD;
      fnBIn   <= bInD;
    end
  end

endmodule : spfs_pin_cell
`default_nettype wire

// File: core/spfs_pin_select.sv
// Shared pin function select: control bits reached over Avalon-MM decide
// which function each of four shared pins carries.
// Assumes one 10 MHz clock, synchronous inputs and an external pad model.
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "spfs_defs.svh"

// Summary of operation
// - Reset puts address/timer pin on address bit.
// - Either timer control bit set selects timer output.
// - Both timer control bits clear restore address bit.
// - Either DMA mode bit selects DMA request 0.
// - Reset puts clock1/end pin on serial clock 1.
// - Clock-1 disable bit selects DMA transfer end.
// - Reset puts receive pin on clocked-serial data.
// - Clear-to-send enable selects clear-to-send input.
module spfs_pin_select (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Avalon-MM slave, byte addressed
  input  wire logic [`SPFS_ADDR_W-1:0]     avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [`SPFS_DATA_W-1:0]     avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [`SPFS_DATA_W-1:0]     avs_readdata,
  output logic                             avs_waitrequest,
  // Address/timer pin functions
  input  wire logic                        addressBitEighteen,
  input  wire logic                        timerOutput,
  // Serial clock 0 / DMA request 0 functions
  input  wire spfs_pkg::spfs_fn_t          serialClockCh0Src,
  output logic                             serialClockCh0In,
  output logic                             dmaRequestCh0_n,
  // Serial clock 1 / DMA transfer end 0 functions
  input  wire spfs_pkg::spfs_fn_t          serialClockCh1Src,
  input  wire logic                        dmaTransferEndCh0_n,
  output logic                             serialClockCh1In,
  // Receive / clear-to-send functions
  output logic                             clockedSerialReceiveData,
  output logic                             clearToSendCh1_n,
  // Pads
  input  wire logic                        addrTimerPinIn,
  output logic                             addrTimerPinOut,
  output logic                             addrTimerPinOe_n,
  input  wire logic                        serialClockCh0PinIn,
  output logic                             serialClockCh0PinOut,
  output logic                             serialClockCh0PinOe_n,
  input  wire logic                        serialClockCh1PinIn,
  output logic                             serialClockCh1PinOut,
  output logic                             serialClockCh1PinOe_n,
  input  wire logic                        rxCtsPinIn,
  output logic                             rxCtsPinOut,
  output logic                             rxCtsPinOe_n
);

  // ========================================================================
  // Decode helpers
  // ========================================================================
  function automatic logic isReg(input logic [`SPFS_ADDR_W-1:0] addr,
                                 input logic [`SPFS_ADDR_W-1:0] ofs);
    isReg = (addr == ofs);
  endfunction : isReg

  function automatic logic anyBit(input logic [`SPFS_CTRL_W-1:0] bits);
    anyBit = |bits;
  endfunction : anyBit

  // ========================================================================
  // Bus handshake
  // ========================================================================
  // One wait cycle per access: the request is seen, then answered with
  // waitrequest low for exactly one cycle, which keeps read data registered.
  spfs_pkg::spfs_bus_t busState_q;
  spfs_pkg::spfs_bus_t busState_d;

  wire logic busReq    = avs_read | avs_write;
  wire logic busAccept = busReq && (busState_q == spfs_pkg::SPFS_BUS_ACK);
  wire logic wrAccept  = busAccept && avs_write && avs_byteenable[`SPFS_LANE_LO];

  always_comb
  begin
    unique case (busState_q)
      spfs_pkg::SPFS_BUS_WAIT: busState_d = busReq ? spfs_pkg::SPFS_BUS_ACK
                                                   : spfs_pkg::SPFS_BUS_WAIT;
      spfs_pkg::SPFS_BUS_ACK:  busState_d = spfs_pkg::SPFS_BUS_WAIT;
    endcase
  end

  // ========================================================================
  // Control bits
  // ========================================================================
  logic [`SPFS_CTRL_W-1:0] timerCtrl_q;
  logic [`SPFS_CTRL_W-1:0] timerCtrl_d;
  logic [`SPFS_CTRL_W-1:0] dmaMode_q;
  logic [`SPFS_CTRL_W-1:0] dmaMode_d;
  logic                    sclk1Disable_q;
  logic                    sclk1Disable_d;
  logic                    cts1Enable_q;
  logic                    cts1Enable_d;

  wire logic wrTimer = wrAccept && isReg(avs_address, `SPFS_OFS_TIMER_CTRL);
  wire logic wrDma   = wrAccept && isReg(avs_address, `SPFS_OFS_DMA_MODE);
  wire logic wrSer   = wrAccept && isReg(avs_address, `SPFS_OFS_SER_CTRL_CH1);
  wire logic wrStat  = wrAccept && isReg(avs_address, `SPFS_OFS_SER_STAT_CH1);

  assign timerCtrl_d    = wrTimer ? avs_writedata[`SPFS_CTRL_W-1:0] : timerCtrl_q;
  assign dmaMode_d      = wrDma ? avs_writedata[`SPFS_CTRL_W-1:0] : dmaMode_q;
  assign sclk1Disable_d = wrSer ? avs_writedata[`SPFS_BIT_SCLK1_DIS] : sclk1Disable_q;
  assign cts1Enable_d   = wrStat ? avs_writedata[`SPFS_BIT_CLEAR_TO_SEND_CH1_EN] : cts1Enable_q;

  // ========================================================================
  // Pin selection
  // ========================================================================
  // Selections follow the next value of the control bits, so a pad changes
  // on the same edge at which the register write lands.
  wire logic selTimer  = anyBit(timerCtrl_d);
  wire logic selDmaReq = anyBit(dmaMode_d);
  wire logic selTend   = sclk1Disable_d;
  wire logic selCts    = cts1Enable_d;

  logic [3:0] sel_q;
  wire  logic [3:0] sel_d = {selCts, selTend, selDmaReq, selTimer};

  // ========================================================================
  // Read data
  // ========================================================================
  logic [`SPFS_DATA_W-1:0] rdData_d;
  logic [`SPFS_DATA_W-1:0] avs_readdata_d;

  wire logic [3:0] padLevels = {rxCtsPinIn, serialClockCh1PinIn,
                                serialClockCh0PinIn, addrTimerPinIn};

  always_comb
  begin
    rdData_d = `SPFS_DATA_ZERO;
    if (isReg(avs_address, `SPFS_OFS_TIMER_CTRL))
      rdData_d[`SPFS_CTRL_W-1:0] = timerCtrl_q;
    else if (isReg(avs_address, `SPFS_OFS_DMA_MODE))
      rdData_d[`SPFS_CTRL_W-1:0] = dmaMode_q;
    else if (isReg(avs_address, `SPFS_OFS_SER_CTRL_CH1))
      rdData_d[`SPFS_BIT_SCLK1_DIS] = sclk1Disable_q;
    else if (isReg(avs_address, `SPFS_OFS_SER_STAT_CH1))
      rdData_d[`SPFS_BIT_CLEAR_TO_SEND_CH1_EN] = cts1Enable_q;
    else if (isReg(avs_address, `SPFS_OFS_PIN_STATUS))
      rdData_d[7:0] = {padLevels, sel_q};
  end

  // Data is loaded while waiting so it stands in the answering cycle.
  assign avs_readdata_d = (busState_q == spfs_pkg::SPFS_BUS_WAIT && avs_read)
                          ? rdData_d : `SPFS_DATA_ZERO;

  // ========================================================================
  // Registers
  // ========================================================================
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busState_q      <= spfs_pkg::SPFS_BUS_WAIT;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `SPFS_DATA_ZERO;
      timerCtrl_q     <= `SPFS_CTRL_RST;
      dmaMode_q       <= `SPFS_CTRL_RST;
      sclk1Disable_q  <= 1'b0;
      cts1Enable_q    <= 1'b0;
      sel_q           <= 4'h0;
    end
    else
    begin
      busState_q      <= busState_d;
      avs_waitrequest <= (busState_d != spfs_pkg::SPFS_BUS_ACK);
      avs_readdata    <= avs_readdata_d;
      timerCtrl_q     <= timerCtrl_d;
      dmaMode_q       <= dmaMode_d;
      sclk1Disable_q  <= sclk1Disable_d;
      cts1Enable_q    <= cts1Enable_d;
      sel_q           <= sel_d;
    end
  end

  // ========================================================================
  // Function sources
  // ========================================================================
  wire spfs_pkg::spfs_fn_t addrFn   = '{level: addressBitEighteen, drive: 1'b1};
  wire spfs_pkg::spfs_fn_t timerFn  = '{level: timerOutput, drive: 1'b1};
  wire spfs_pkg::spfs_fn_t inputFn  = '{level: `SPFS_LINE_LOW, drive: 1'b0};
  wire spfs_pkg::spfs_fn_t tendFn   = '{level: dmaTransferEndCh0_n, drive: 1'b1};

  // ========================================================================
  // Pins
  // ========================================================================
  // Reset forces every select low through the control bits, so each pad
  // comes up on its first function; the reset drive state and the idle levels differ per pin.
  spfs_pin_cell #(
    .RST_OE_N (1'b0),
    .IDLE_A   (`SPFS_LINE_LOW),
    .IDLE_B   (`SPFS_LINE_LOW)
  ) u_addrTimer (
    .clk     (clk),
    .rst_n   (rst_n),
    .selB    (selTimer),
    .fnA     (addrFn),
    .fnB     (timerFn),
    .fnAIn   (),
    .fnBIn   (),
    .padIn   (addrTimerPinIn),
    .padOut  (addrTimerPinOut),
    .padOe_n (addrTimerPinOe_n)
  );

  spfs_pin_cell #(
    .RST_OE_N (1'b1),
    .IDLE_A   (`SPFS_LINE_IDLE),
    .IDLE_B   (`SPFS_LINE_IDLE)
  ) u_sclk0DmaReq (
    .clk     (clk),
    .rst_n   (rst_n),
    .selB    (selDmaReq),
    .fnA     (serialClockCh0Src),
    .fnB     (inputFn),
    .fnAIn   (serialClockCh0In),
    .fnBIn   (dmaRequestCh0_n),
    .padIn   (serialClockCh0PinIn),
    .padOut  (serialClockCh0PinOut),
    .padOe_n (serialClockCh0PinOe_n)
  );

  spfs_pin_cell #(
    .RST_OE_N (1'b1),
    .IDLE_A   (`SPFS_LINE_IDLE),
    .IDLE_B   (`SPFS_LINE_IDLE)
  ) u_sclk1Tend (
    .clk     (clk),
    .rst_n   (rst_n),
    .selB    (selTend),
    .fnA     (serialClockCh1Src),
    .fnB     (tendFn),
    .fnAIn   (serialClockCh1In),
    .fnBIn   (),
    .padIn   (serialClockCh1PinIn),
    .padOut  (serialClockCh1PinOut),
    .padOe_n (serialClockCh1PinOe_n)
  );

  spfs_pin_cell #(
    .RST_OE_N (1'b1),
    .IDLE_A   (`SPFS_LINE_IDLE),
    .IDLE_B   (`SPFS_LINE_IDLE)
  ) u_rxCts (
    .clk     (clk),
    .rst_n   (rst_n),
    .selB    (selCts),
    .fnA     (inputFn),
    .fnB     (inputFn),
    .fnAIn   (clockedSerialReceiveData),
    .fnBIn   (clearToSendCh1_n),
    .padIn   (rxCtsPinIn),
    .padOut  (rxCtsPinOut),
    .padOe_n (rxCtsPinOe_n)
  );

endmodule : spfs_pin_select
`default_nettype wire

// File: bench/spfs_pin_select_assertions.sv
// Concurrent checks on the shared pin select ports.
// Assumes it is bound to spfs_pin_select; control bits are shadowed from bus writes.
`timescale 1ns/100ps
`default_nettype none
`include "spfs_defs.svh"
module spfs_pin_select_assertions (
  // Clock, reset and bus
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [`SPFS_ADDR_W-1:0] avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [`SPFS_DATA_W-1:0] avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic                    avs_waitrequest,
  // Function sources and pad levels
  input wire logic                    addressBitEighteen,
  input wire logic                    timerOutput,
  input wire spfs_pkg::spfs_fn_t      serialClockCh0Src,
  input wire spfs_pkg::spfs_fn_t      serialClockCh1Src,
  input wire logic                    dmaTransferEndCh0_n,
  input wire logic                    serialClockCh0PinIn,
  input wire logic                    serialClockCh1PinIn,
  input wire logic                    rxCtsPinIn,
  // Watched outputs
  input wire logic                    addrTimerPinOut,
  input wire logic                    addrTimerPinOe_n,
  input wire logic                    serialClockCh0PinOut,
  input wire logic                    serialClockCh0PinOe_n,
  input wire logic                    serialClockCh0In,
  input wire logic                    dmaRequestCh0_n,
  input wire logic                    serialClockCh1PinOut,
  input wire logic                    serialClockCh1PinOe_n,
  input wire logic                    serialClockCh1In,
  input wire logic                    clockedSerialReceiveData,
  input wire logic                    clearToSendCh1_n,
  input wire logic                    rxCtsPinOut,
  input wire logic                    rxCtsPinOe_n
);
  // ==========================================================================
  // Shadow of the select bits, order {cts, tend, dmareq, timer}
  // ==========================================================================
  // The shadow uses the value being written, since pins switch at the accept edge.
  logic [3:0] sel_q;
  wire        accept = avs_write & ~avs_waitrequest & avs_byteenable[`SPFS_LANE_LO];
  wire [3:0]  hit    = {4{accept}} & {avs_address == `SPFS_OFS_SER_STAT_CH1,
                        avs_address == `SPFS_OFS_SER_CTRL_CH1,
                        avs_address == `SPFS_OFS_DMA_MODE, avs_address == `SPFS_OFS_TIMER_CTRL};
  wire        anyLow = |avs_writedata[1:0];
  wire [3:0]  newBit = {avs_writedata[0], avs_writedata[0], anyLow, anyLow};
  wire [3:0]  sel_d  = (hit & newBit) | (~hit & sel_q);
  always_ff @(posedge clk) sel_q <= rst_n ? sel_d : 4'h0;

  // ==========================================================================
  // Expected levels, one edge ahead of the registered outputs
  // ==========================================================================
  // Named wires keep every $past on a plain signal.
  wire        expTmr  = sel_d[0] ? timerOutput : addressBitEighteen;
  wire        expOut0 = sel_d[1] ? 1'b0 : serialClockCh0Src.level;
  wire        expOe0  = sel_d[1] | !serialClockCh0Src.drive;
  wire        expReq  = sel_d[1] ? serialClockCh0PinIn : 1'b1;
  wire        expClk0 = sel_d[1] ? 1'b1 : serialClockCh0PinIn;
  wire        expOut1 = sel_d[2] ? dmaTransferEndCh0_n : serialClockCh1Src.level;
  wire        expOe1  = !sel_d[2] & !serialClockCh1Src.drive;
  wire        expClk1 = sel_d[2] ? 1'b1 : serialClockCh1PinIn;
  wire        expCts  = sel_d[3] ? rxCtsPinIn : 1'b1;
  wire        expRx   = sel_d[3] ? 1'b1 : rxCtsPinIn;

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_busAnswer;
    (avs_read | avs_write) && avs_waitrequest |=> s_ack;
  endproperty
  property p_rstAddr;
    $rose(rst_n) |-> !addrTimerPinOe_n && !addrTimerPinOut;
  endproperty
  property p_rstSclk;
    $rose(rst_n) |-> serialClockCh1PinOe_n && serialClockCh1In && serialClockCh0In;
  endproperty
  property p_rstRx;
    $rose(rst_n) |-> rxCtsPinOe_n && clockedSerialReceiveData && clearToSendCh1_n;
  endproperty
  property p_tmrSel;
    $past(rst_n) |-> !addrTimerPinOe_n && addrTimerPinOut == $past(expTmr);
  endproperty
  property p_sclk0Sel;
    $past(rst_n) |-> serialClockCh0PinOe_n == $past(expOe0)
      && serialClockCh0PinOut == $past(expOut0);
  endproperty
  property p_dmaReqIn;
    $past(rst_n) |-> dmaRequestCh0_n == $past(expReq)
      && serialClockCh0In == $past(expClk0);
  endproperty
  property p_sclk1Sel;
    $past(rst_n) |-> serialClockCh1PinOut == $past(expOut1)
      && serialClockCh1PinOe_n == $past(expOe1)
      && serialClockCh1In == $past(expClk1);
  endproperty
  property p_ctsSel;
    $past(rst_n) |-> rxCtsPinOe_n && !rxCtsPinOut
      && clearToSendCh1_n == $past(expCts)
      && clockedSerialReceiveData == $past(expRx);
  endproperty

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_busAnswer: assert property (p_busAnswer) else $error("bus answer not one cycle");
  a_rstAddr: assert property (p_rstAddr) else $error("address pin reset wrong");
  a_rstSclk: assert property (p_rstSclk) else $error("clock pin reset wrong");
  a_rstRx: assert property (p_rstRx) else $error("receive pin reset wrong");
  a_tmrSel: assert property (p_tmrSel) else $error("timer pin select wrong");
  a_sclk0Sel: assert property (p_sclk0Sel) else $error("clock 0 pin wrong");
  a_dmaReqIn: assert property (p_dmaReqIn) else $error("request input wrong");
  a_sclk1Sel: assert property (p_sclk1Sel) else $error("clock 1 pin wrong");
  a_ctsSel: assert property (p_ctsSel) else $error("receive pin select wrong");
endmodule : spfs_pin_select_assertions
`default_nettype wire

// File: bench/spfs_pad_model.sv
// Outside circuitry on the four shared pads.
// Assumes the bench supplies the level the outside drives on a released pad.
`timescale 1ns/100ps
`default_nettype none
module spfs_pad_model (
  // Pad drivers from the block
  input  wire logic [3:0] padOut,
  input  wire logic [3:0] padOe_n,
  // Levels driven from outside
  input  wire logic [3:0] extLevel,
  // Resolved pads
  output logic      [3:0] padLevel
);
  // Outside drives only where the block lets go, so no contention is modelled.
  assign padLevel = (padOe_n & extLevel) | (~padOe_n & padOut);
endmodule : spfs_pad_model
`default_nettype wire

// File: bench/tb_spfs_pin_select.sv
// Self-checking bench for the shared pin select block.
// Assumes design, pad model and checker are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
`include "spfs_defs.svh"
module tb_spfs_pin_select;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic                    clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [`SPFS_ADDR_W-1:0] avs_address;
  logic [`SPFS_DATA_W-1:0] avs_writedata, avs_readdata, rd;
  logic [3:0]              avs_byteenable, extLevel, padLevel;
  logic                    addressBitEighteen, timerOutput, dmaTransferEndCh0_n;
  spfs_pkg::spfs_fn_t      serialClockCh0Src, serialClockCh1Src;
  logic                    serialClockCh0In, dmaRequestCh0_n, serialClockCh1In;
  logic                    clockedSerialReceiveData, clearToSendCh1_n;
  logic                    addrTimerPinIn, addrTimerPinOut, addrTimerPinOe_n;
  logic                    serialClockCh0PinIn, serialClockCh0PinOut, serialClockCh0PinOe_n;
  logic                    serialClockCh1PinIn, serialClockCh1PinOut, serialClockCh1PinOe_n;
  logic                    rxCtsPinIn, rxCtsPinOut, rxCtsPinOe_n;
  logic [7:0]              pinView;
  logic [4:0]              ofs [4];
  logic [31:0]             msk [4];
  int                      n_mismatch, num_checks;

  spfs_pin_select uut (.*);
  spfs_pad_model u_pads (
    .padOut   ({rxCtsPinOut, serialClockCh1PinOut, serialClockCh0PinOut, addrTimerPinOut}),
    .padOe_n  ({rxCtsPinOe_n, serialClockCh1PinOe_n, serialClockCh0PinOe_n, addrTimerPinOe_n}),
    .extLevel (extLevel),
    .padLevel (padLevel)
  );
  assign {rxCtsPinIn, serialClockCh1PinIn, serialClockCh0PinIn, addrTimerPinIn} = padLevel;
  assign pinView = {clockedSerialReceiveData, clearToSendCh1_n, serialClockCh1PinOut,
                    serialClockCh1PinOe_n, serialClockCh0PinOe_n, dmaRequestCh0_n,
                    addrTimerPinOut, addrTimerPinOe_n};
  always #50 clk = ~clk;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask : check

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (k >= 50)
    begin
      n_mismatch++;
      wrap_up();
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask : bus

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial
  begin
    clk = 1'b0; rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 5'h00; avs_writedata = 32'h0; avs_byteenable = 4'h0; extLevel = 4'h0;
    addressBitEighteen = 1'b0; timerOutput = 1'b1; dmaTransferEndCh0_n = 1'b1;
    serialClockCh0Src = 2'h1; serialClockCh1Src = 2'h1;
    ofs = '{`SPFS_OFS_TIMER_CTRL, `SPFS_OFS_DMA_MODE, `SPFS_OFS_SER_CTRL_CH1,
            `SPFS_OFS_SER_STAT_CH1};
    msk = '{32'h3, 32'h3, 32'h1, 32'h1};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `SPFS_OFS_PIN_STATUS, 32'h0, 4'hF);
    check("reset select", rd & 32'hF, 32'h0);
    // The last value returns to zero so every pin is seen leaving its alternate.
    for (int r = 0; r < 4; r++)
      for (int v = 0; v < 5; v++)
      begin
        bus(1'b1, ofs[r], 32'(v % 4), 4'h1);
        bus(1'b0, ofs[r], 32'h0, 4'hF);
        check("control", rd, 32'(v % 4) & msk[r]);
        bus(1'b0, `SPFS_OFS_PIN_STATUS, 32'h0, 4'hF);
        check("select", (rd >> r) & 32'h1, 32'((32'(v % 4) & msk[r]) != 0));
        check("pins", {30'h0, pinView[2 * r +: 2]}, {30'h0, rd[r], r[0] ? !rd[r] : 1'b0});
      end
    bus(1'b1, `SPFS_OFS_TIMER_CTRL, 32'h3, 4'hE);
    bus(1'b0, `SPFS_OFS_TIMER_CTRL, 32'h0, 4'hF);
    check("lane off", rd, 32'h0);
    bus(1'b1, 5'h14, 32'h3, 4'hF);
    bus(1'b0, 5'h14, 32'h0, 4'hF);
    check("unmapped", rd, 32'h0);
    for (int r = 0; r < 4; r++)
      bus(1'b1, ofs[r], 32'h1, 4'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("reset pins", {24'h0, pinView & 8'hDF}, 32'hDC);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, `SPFS_OFS_PIN_STATUS, 32'h0, 4'hF);
    check("select after reset", rd & 32'hF, 32'h0);
    wrap_up();
  end
endmodule : tb_spfs_pin_select

bind spfs_pin_select spfs_pin_select_assertions u_chk (.*);
`default_nettype wire
